// ===== logic/cfg_map.svh
// offsets, field positions, fixed values and counts of the config block
// assumes byte addressed configuration space, dword aligned accesses
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH

// configuration offsets, bytes
`define CMD_OFFSET 8'h04
`define STATUS_OFFSET 8'h06
`define CLASS_OFFSET 8'h08

// command word field
`define CMD_PERR_EN_BIT 6

// status field positions, within the 16-bit status half
`define STAT_DEVSEL_HI 10
`define STAT_DEVSEL_LO 9
`define STAT_PARITY_BIT 8
`define STAT_B2B_BIT 7
`define STAT_USER_FEAT_BIT 6
`define STAT_HICLK_BIT 5
`define STAT_CAP_LIST_BIT 4
`define STAT_RSVD_HI 3
`define STAT_RSVD_LO 0

// status fixed values
`define DEVSEL_MEDIUM 2'h1
`define STATUS_RESET 16'h0210

// class word fields
`define BASE_CLASS 8'h0c
`define SUB_CLASS 8'h00
`define PROG_IF 8'h10

// reset values
`define PERR_EN_RESET 1'h0
`define PARITY_FLAG_RESET 1'h0

// device select delay after address phase, medium decode, clocks
`define DEVSEL_DELAY 2'h2

`endif

// ===== logic/cfg_pkg.sv
// types shared by the config status and class block
// assumes cfg_map.svh supplies all numbers
package cfg_pkg;

  // one configuration access as presented by the bus front end
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_access_t;

  // device select sequencer
  typedef enum logic [1:0] {
    dsel_idle = 2'b00,
    dsel_wait = 2'b01,
    dsel_drive = 2'b10
  } devsel_state_t;

  // parity error pin sequencer
  typedef enum logic [1:0] {
    perr_idle = 2'b00,
    perr_low = 2'b01,
    perr_high = 2'b10
  } perr_state_t;

endpackage : cfg_pkg

// ===== logic/parity_flag.sv
// sticky master data parity flag, write one to clear
// assumes set and clear are already qualified by the caller
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.svh"

module parity_flag import cfg_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic set_event,
  input wire logic clear_req,
  output logic flag
);

  logic next_flag; // next flag value

  // set wins over a clear landing in the same cycle
  always_comb begin
    next_flag = set_event | (flag & ~clear_req);
  end

  // register only
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag <= `PARITY_FLAG_RESET;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : parity_flag
`default_nettype wire

// ===== logic/devsel_timer.sv
// device select driver with medium decode timing
// assumes target_hit is a one-cycle pulse for a non-config access
// assumes xfer_done marks the last data phase of that access
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.svh"

module devsel_timer import cfg_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic target_hit,
  input wire logic xfer_done,
  output logic device_select_n_out,
  output logic device_select_oe_n
);

  devsel_state_t state, next_state; // sequencer
  logic [1:0] count, next_count; // clocks since the hit
  logic next_dsel_n; // next pin level
  logic next_dsel_oe_n; // next pin enable

  // hits while busy are ignored, one access at a time
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      dsel_idle: begin
        if (target_hit) begin
          next_state = dsel_wait;
          next_count = 2'h1;
        end
      end
      dsel_wait: begin
        if (count == `DEVSEL_DELAY - 2'h1) begin
          next_state = dsel_drive;
        end else begin
          next_count = count + 2'h1;
        end
      end
      dsel_drive: begin
        if (xfer_done) begin
          next_state = dsel_idle;
        end
      end
      default: begin
        next_state = dsel_idle; // illegal code recovers
      end
    endcase
    next_dsel_n = (next_state != dsel_drive);
    next_dsel_oe_n = (next_state != dsel_drive);
  end

  // register only
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= dsel_idle;
      count <= 2'h0;
      device_select_n_out <= 1'h1;
      device_select_oe_n <= 1'h1;
    end else begin
      state <= next_state;
      count <= next_count;
      device_select_n_out <= next_dsel_n;
      device_select_oe_n <= next_dsel_oe_n;
    end
  end

  default clocking dcb @(posedge mclk); endclocking
  default disable iff (rst);

  a_devsel_medium: assert property (
    (target_hit && state == dsel_idle) |-> ##2 !device_select_n_out
  ) else $error("device select not low two clocks after hit");

  a_devsel_not_fast: assert property (
    (target_hit && state == dsel_idle) |=> device_select_n_out
  ) else $error("device select asserted at fast timing");

endmodule : devsel_timer
`default_nettype wire

// ===== logic/cfg_status_class.sv
// status half-word and class/revision word of the config header
// assumes one config access per cfg_req pulse, answered next clock
// assumes pin inputs are already synchronous to mclk
//
// Summary of operation
// - devsel code 01b, medium timing asserted
// - parity flag needs perr, mastership, enable
// - back-to-back capable bit reads zero
// - user features bit reads zero
// - high clock capable bit reads zero
// - capability list bit reads one
// - status bits three to zero zero
// - base class byte is serial bus
// - subclass byte all zero
// - programming interface byte is 10h
// - low byte is fixed silicon revision
// - class word read-only at offset 08h
// - perr driven only when enable set
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.svh"

module cfg_status_class import cfg_pkg::*; #(
  // arbitrary revision code, set per tape-out
  parameter logic [7:0] SILICON_REVISION = 8'h5a
) (
  input wire logic mclk,
  input wire logic rst,
  // configuration access
  input wire logic cfg_req,
  input wire cfg_access_t cfg_access,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // parity error pin, tri-state, driven high one clock before release
  input wire logic parity_error_signal_n_in,
  output logic parity_error_signal_n_out,
  output logic parity_error_signal_oe_n,
  // data phase context from the bus engine
  input wire logic master_data_phase,
  input wire logic parity_detected,
  // device select pin
  input wire logic target_hit,
  input wire logic xfer_done,
  output logic device_select_signal_n_out,
  output logic device_select_signal_oe_n,
  // state seen by the rest of the chip
  output logic master_data_parity_flag,
  output logic parity_response_enable
);

  // ---- access decode ----

  logic [7:0] dword_addr; // access address, low bits dropped
  logic hit_cmd; // dword holding command and status
  logic hit_class; // class and revision dword
  logic wr_cmd; // write into command/status dword

  // the status half shares the dword at the command offset
  always_comb begin
    dword_addr = {cfg_access.addr[7:2], 2'h0};
    hit_cmd = (dword_addr == `CMD_OFFSET);
    hit_class = (dword_addr == `CLASS_OFFSET);
    wr_cmd = cfg_req & cfg_access.write & hit_cmd;
  end

  // ---- parity response enable ----

  logic next_perr_en; // next enable value

  // only bit 6 of the command word is held here
  always_comb begin
    next_perr_en = parity_response_enable;
    if (wr_cmd && cfg_access.byte_en[0]) begin
      next_perr_en = cfg_access.wdata[`CMD_PERR_EN_BIT];
    end
  end

  // register only
  always_ff @(posedge mclk) begin
    if (rst) begin
      parity_response_enable <= `PERR_EN_RESET;
    end else begin
      parity_response_enable <= next_perr_en;
    end
  end

  // ---- master data parity flag ----

  logic flag_set; // qualified set event
  logic flag_clear; // host write of one

  // all three conditions in the same data phase
  always_comb begin
    flag_set = ~parity_error_signal_n_in
      & master_data_phase
      & parity_response_enable;
    // the status parity bit sits in byte lane 3 of the dword
    flag_clear = wr_cmd & cfg_access.byte_en[3]
      & cfg_access.wdata[16 + `STAT_PARITY_BIT];
  end

  // sticky flag; a zero write leaves it alone
  parity_flag u_parity_flag (
    .mclk(mclk),
    .rst(rst),
    .set_event(flag_set),
    .clear_req(flag_clear),
    .flag(master_data_parity_flag)
  );

  // ---- parity error pin ----

  perr_state_t perr_state, next_perr_state; // pin sequencer
  logic next_perr_n; // next pin level
  logic next_perr_oe_n; // next pin enable

  // drive low, then high for one clock before release,
  // so the pull-up does not have to restore the line alone
  always_comb begin
    next_perr_state = perr_state;
    unique case (perr_state)
      perr_idle: begin
        if (parity_detected && parity_response_enable) begin
          next_perr_state = perr_low;
        end
      end
      perr_low: begin
        if (parity_detected && parity_response_enable) begin
          next_perr_state = perr_low;
        end else begin
          next_perr_state = perr_high;
        end
      end
      perr_high: begin
        // a fresh error in the release cycle must not be lost
        if (parity_detected && parity_response_enable) begin
          next_perr_state = perr_low;
        end else begin
          next_perr_state = perr_idle;
        end
      end
      default: begin
        next_perr_state = perr_idle; // illegal code recovers
      end
    endcase
    next_perr_n = (next_perr_state != perr_low);
    next_perr_oe_n = (next_perr_state == perr_idle);
  end

  // register only
  always_ff @(posedge mclk) begin
    if (rst) begin
      perr_state <= perr_idle;
      parity_error_signal_n_out <= 1'h1;
      parity_error_signal_oe_n <= 1'h1;
    end else begin
      perr_state <= next_perr_state;
      parity_error_signal_n_out <= next_perr_n;
      parity_error_signal_oe_n <= next_perr_oe_n;
    end
  end

  // ---- device select ----

  // medium decode timing for non-config accesses
  devsel_timer u_devsel_timer (
    .mclk(mclk),
    .rst(rst),
    .target_hit(target_hit),
    .xfer_done(xfer_done),
    .device_select_n_out(device_select_signal_n_out),
    .device_select_oe_n(device_select_signal_oe_n)
  );

  // ---- read data ----

  logic [15:0] status_word; // assembled status half
  logic [31:0] class_word; // assembled class word
  logic [31:0] next_rdata; // next read data
  logic next_ack; // next answer strobe

  // hardwired bits are plain constants, writes cannot reach them
  always_comb begin
    status_word = 16'h0000;
    status_word[`STAT_DEVSEL_HI:`STAT_DEVSEL_LO] = `DEVSEL_MEDIUM;
    status_word[`STAT_PARITY_BIT] = master_data_parity_flag;
    status_word[`STAT_B2B_BIT] = 1'h0;
    status_word[`STAT_USER_FEAT_BIT] = 1'h0;
    status_word[`STAT_HICLK_BIT] = 1'h0;
    status_word[`STAT_CAP_LIST_BIT] = 1'h1;
    status_word[`STAT_RSVD_HI:`STAT_RSVD_LO] = 4'h0;
    class_word = {`BASE_CLASS,
      `SUB_CLASS,
      `PROG_IF,
      SILICON_REVISION};
  end

  // every access is answered; unmapped reads return zero
  always_comb begin
    next_ack = cfg_req;
    next_rdata = 32'h0000_0000;
    if (cfg_req && !cfg_access.write) begin
      if (hit_cmd) begin
        // command half: only the enable bit lives here
        next_rdata = {status_word, 16'h0000};
        next_rdata[`CMD_PERR_EN_BIT] = parity_response_enable;
      end else if (hit_class) begin
        next_rdata = class_word;
      end
    end
  end

  // register only
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ack <= 1'h0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= next_ack;
      cfg_rdata <= next_rdata;
    end
  end

  // ---- checks ----

  default clocking ccb @(posedge mclk); endclocking
  default disable iff (rst);

  logic rd_cmd; // read of the status dword
  logic rd_class; // read of the class dword
  always_comb begin
    rd_cmd = cfg_req & ~cfg_access.write & hit_cmd;
    rd_class = cfg_req & ~cfg_access.write & hit_class;
  end

  a_status_fixed: assert property (
    rd_cmd |=> (cfg_rdata[26:25] == 2'h1) && (cfg_rdata[23:16] == 8'h10)
  ) else $error("status fixed bits wrong");

  a_flag_set: assert property (
    flag_set |=> master_data_parity_flag ##1 master_data_parity_flag
  ) else $error("parity flag not set by its event");

  a_flag_cause: assert property (
    $rose(master_data_parity_flag) |->
      $past(master_data_phase) && $past(parity_response_enable)
  ) else $error("parity flag set without cause");

  a_flag_sticky: assert property (
    (master_data_parity_flag && !flag_clear) |=> master_data_parity_flag
  ) else $error("parity flag lost without clear");

  a_flag_clear: assert property (
    (flag_clear && !flag_set) |=> !master_data_parity_flag
  ) else $error("parity flag not cleared by one");

  a_flag_readback: assert property (
    rd_cmd |=> cfg_rdata[24] == $past(master_data_parity_flag)
  ) else $error("parity flag read back wrong");

  a_class_value: assert property (
    rd_class |=> cfg_rdata == {8'h0c, 8'h00, 8'h10, SILICON_REVISION}
  ) else $error("class word wrong");

  a_perr_gate: assert property (
    (perr_state == perr_idle && !parity_response_enable) |=>
      parity_error_signal_oe_n
  ) else $error("parity pin driven while disabled");

  a_perr_drive: assert property (
    (parity_detected && parity_response_enable) |=>
      !parity_error_signal_oe_n && !parity_error_signal_n_out
  ) else $error("parity pin not driven");

  a_ack_write: assert property (
    (cfg_req && cfg_access.write) |=> cfg_ack && cfg_rdata == 32'h0
  ) else $error("write not answered");

  a_cmd_other_zero: assert property (
    rd_cmd |=> (cfg_rdata[15:7] == 9'h000) && (cfg_rdata[5:0] == 6'h00)
  ) else $error("unused command bits not zero");

  a_enable_write: assert property (
    (wr_cmd && cfg_access.byte_en[0]) |=>
      parity_response_enable == $past(cfg_access.wdata[`CMD_PERR_EN_BIT])
  ) else $error("parity response enable not written");

  // a disabled response must also keep the flag from setting
  a_flag_blocked: assert property (
    (!parity_response_enable && !master_data_parity_flag) |=>
      !master_data_parity_flag
  ) else $error("parity flag set while response disabled");

  // one driven-high cycle before the pin is let go
  a_perr_release: assert property (
    (perr_state == perr_low && !(parity_detected && parity_response_enable)) |=>
      !parity_error_signal_oe_n && parity_error_signal_n_out
  ) else $error("parity pin not driven high before release");

  c_flag_set: cover property (flag_set ##1 master_data_parity_flag);
  c_flag_clear: cover property (master_data_parity_flag ##1 flag_clear);
  c_class_read: cover property (rd_class ##1 cfg_ack);
  c_perr_seq: cover property (perr_state == perr_low ##1 perr_state == perr_high);

endmodule : cfg_status_class
`default_nettype wire

// ===== testbench/pci_host_model.sv
// behavioural host bridge: config cycles and the shared parity error line
// assumes the device answers each request exactly one clock after it is taken
`timescale 1ns/1ps
`default_nettype none

module pci_host_model import cfg_pkg::*; (
  input wire logic mclk,
  output logic cfg_req,
  output var cfg_access_t cfg_access,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic other_perr,
  input wire logic perr_n_out,
  input wire logic perr_oe_n,
  output logic perr_n_in
);
  // pulled-up line, low when the device or another agent pulls it
  assign perr_n_in = (perr_oe_n ? 1'b1 : perr_n_out) & ~other_perr;

  // bus idle at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_access = '0;
  end

  // one config cycle: request for one clock, answer caught on the next
  task automatic access(input cfg_access_t a, output logic [31:0] rd, output logic ok);
    @(posedge mclk);
    cfg_req <= 1'b1;
    cfg_access <= a;
    @(posedge mclk);
    cfg_req <= 1'b0;
    // released bus shows the inverse, so a stale copy is never mistaken
    cfg_access <= ~a;
    #1;
    ok = cfg_ack;
    rd = cfg_rdata;
  endtask : access
endmodule : pci_host_model

`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the status half-word and class word
// assumes the host model drives config cycles and resolves the parity line
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cfg_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // arbitrary revision code
  logic mclk, rst, other_perr, master_data_phase, parity_detected, target_hit, xfer_done;
  logic cfg_req, cfg_ack, perr_n_in, perr_n_out, perr_oe_n, ds_n, ds_oe_n, flag, en;
  cfg_access_t cfg_access; // request fields from the host model
  logic [31:0] cfg_rdata; // answer data
  int bad_count, n_compared, seed; // score and random state
  logic e_m, f_m; // expected enable and flag

  cfg_status_class #(.SILICON_REVISION(REV)) u_cfg_status_class (
    .mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_access(cfg_access),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .parity_error_signal_n_in(perr_n_in),
    .parity_error_signal_n_out(perr_n_out), .parity_error_signal_oe_n(perr_oe_n),
    .master_data_phase(master_data_phase), .parity_detected(parity_detected),
    .target_hit(target_hit), .xfer_done(xfer_done), .device_select_signal_n_out(ds_n),
    .device_select_signal_oe_n(ds_oe_n), .master_data_parity_flag(flag),
    .parity_response_enable(en));

  pci_host_model u_pci_host_model (
    .mclk(mclk), .cfg_req(cfg_req), .cfg_access(cfg_access), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .other_perr(other_perr), .perr_n_out(perr_n_out),
    .perr_oe_n(perr_oe_n), .perr_n_in(perr_n_in));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // expected read data from the field definitions
  function automatic logic [31:0] expect_read(input logic [7:0] ad);
    case (ad[7:2])
      6'h01: expect_read = {5'h00, 2'h1, f_m, 4'h1, 4'h0, 9'h000, e_m, 6'h00};
      6'h02: expect_read = {8'h0c, 8'h00, 8'h10, REV};
      default: expect_read = 32'h0; // unmapped reads as zero
    endcase
  endfunction : expect_read

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // config access, answer checked, model of the writable bits updated
  task automatic acc(input logic w, input logic [7:0] ad, input logic [3:0] be,
                     input logic [31:0] wd);
    logic [31:0] rd;
    logic ok;
    logic [31:0] exp;
    exp = w ? 32'h0 : expect_read(ad);
    u_pci_host_model.access('{w, ad, be, wd}, rd, ok);
    chk({31'h0, ok}, 32'h1);
    chk(rd, exp);
    if (w && ad[7:2] == 6'h01) begin
      if (be[0]) e_m = wd[6];
      if (be[3] && wd[24]) f_m = 1'b0;
    end
  endtask : acc

  // another agent pulls the parity line for one clock
  task automatic perr_event(input logic m);
    @(posedge mclk);
    other_perr <= 1'b1;
    master_data_phase <= m;
    @(posedge mclk);
    other_perr <= 1'b0;
    master_data_phase <= 1'b0;
    f_m = f_m | (e_m & m);
    @(posedge mclk);
    #1;
    chk({31'h0, flag}, {31'h0, f_m});
  endtask : perr_event

  // detected parity error; pin walk depends on the enable
  task automatic detect(input logic on);
    @(posedge mclk);
    parity_detected <= 1'b1;
    @(posedge mclk);
    parity_detected <= 1'b0;
    #1;
    chk({30'h0, perr_oe_n, perr_n_out}, on ? 32'h0 : 32'h3);
    @(posedge mclk);
    #1;
    chk({30'h0, perr_oe_n, perr_n_out}, on ? 32'h1 : 32'h3);
    @(posedge mclk);
    #1;
    chk({31'h0, perr_oe_n}, 32'h1);
  endtask : detect

  // verdict, the single end of the run
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // watchdog, far beyond the roughly 145 clocks the tests take
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  // main sequence
  initial begin
    logic [31:0] r;
    {mclk, other_perr, master_data_phase, parity_detected, target_hit, xfer_done} = '0;
    rst = 1'b1;
    {bad_count, n_compared, e_m, f_m} = '0;
    seed = 74;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({28'h0, flag, en, perr_oe_n, ds_oe_n}, 32'h3);
    acc(1'b0, 8'h08, 4'hf, 32'h0);
    acc(1'b0, 8'h04, 4'hf, 32'h0);
    acc(1'b0, 8'h00, 4'hf, 32'h0);
    $display("test reset values done");
    // fixed fields take writes of all ones without change
    acc(1'b1, 8'h08, 4'hf, 32'hffffffff);
    acc(1'b1, 8'h04, 4'hf, 32'hffffffbf);
    acc(1'b0, 8'h08, 4'hf, 32'h0);
    acc(1'b0, 8'h04, 4'hf, 32'h0);
    $display("test fixed fields done");
    // random mix of reads and writes over the first four dwords
    repeat (40) begin
      r = $random(seed);
      acc(r[8], {4'h0, r[3:2], 2'b00}, r[15:12], $random(seed));
      chk({31'h0, en}, {31'h0, e_m});
    end
    $display("test random accesses done");
    acc(1'b1, 8'h04, 4'h1, 32'h0);
    perr_event(1'b1);
    acc(1'b1, 8'h04, 4'h1, 32'h40);
    perr_event(1'b0);
    perr_event(1'b1);
    acc(1'b0, 8'h04, 4'hf, 32'h0);
    acc(1'b1, 8'h04, 4'hf, 32'h00000040);
    acc(1'b1, 8'h04, 4'h7, 32'h01000040);
    acc(1'b1, 8'h04, 4'h8, 32'h01000000);
    chk({31'h0, flag}, {31'h0, f_m});
    $display("test parity flag done");
    detect(1'b1);
    acc(1'b1, 8'h04, 4'h1, 32'h0);
    detect(1'b0);
    $display("test parity pin done");
    @(posedge mclk);
    target_hit <= 1'b1;
    @(posedge mclk);
    target_hit <= 1'b0;
    #1;
    chk({30'h0, ds_oe_n, ds_n}, 32'h3);
    @(posedge mclk);
    #1;
    chk({30'h0, ds_oe_n, ds_n}, 32'h0);
    repeat (3) @(posedge mclk);
    #1;
    chk({30'h0, ds_oe_n, ds_n}, 32'h0);
    @(posedge mclk);
    xfer_done <= 1'b1;
    @(posedge mclk);
    xfer_done <= 1'b0;
    #1;
    chk({30'h0, ds_oe_n, ds_n}, 32'h3);
    $display("test device select done");
    complete_run();
  end
endmodule : tb

`default_nettype wire
